/* File: hdl/lcd_bias_driver.sv */
`timescale 1ns/1ps
`default_nettype none

module lcd_bias_driver (
  // clock and reset
  input  wire logic                                   ref_clk,
  input  wire logic                                   sys_rst,
  // axi4-lite write address
  input  wire logic [lcd_bias_pkg::AXI_ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                                   s_axi_awvalid,
  output logic                                        s_axi_awready,
  // axi4-lite write data
  input  wire logic [lcd_bias_pkg::AXI_DATA_W-1:0]    s_axi_wdata,
  input  wire logic [3:0]                             s_axi_wstrb,
  input  wire logic                                   s_axi_wvalid,
  output logic                                        s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                                  s_axi_bresp,
  output logic                                        s_axi_bvalid,
  input  wire logic                                   s_axi_bready,
  // axi4-lite read address
  input  wire logic [lcd_bias_pkg::AXI_ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                                   s_axi_arvalid,
  output logic                                        s_axi_arready,
  // axi4-lite read data
  output logic [lcd_bias_pkg::AXI_DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                                  s_axi_rresp,
  output logic                                        s_axi_rvalid,
  input  wire logic                                   s_axi_rready,
  // shared port data bits
  input  wire logic [lcd_bias_pkg::PIN_COUNT-1:0]     pin_data,
  // pin drive
  output lcd_bias_pkg::level_t                        pin_level [lcd_bias_pkg::PIN_COUNT],
  output logic [lcd_bias_pkg::PIN_COUNT-1:0]          pin_lcd_drive,
  output logic [1:0]                                  bias_current_sel
);

  localparam int unsigned NP = lcd_bias_pkg::PIN_COUNT;
  localparam int unsigned NR = lcd_bias_pkg::ROLE_REGS;
  localparam int unsigned RW = lcd_bias_pkg::REG_WIDTH;

  ////////////////////////////////////////////////////////////////////////////////
  // write channel holding registers

  logic [lcd_bias_pkg::AXI_ADDR_W-1:0] aw_addr_q;
  logic                                aw_full_q;
  logic [RW-1:0]                       w_data_q;
  logic                                w_lane0_q;
  logic                                w_full_q;
  logic                                bvalid_q;
  logic [1:0]                          bresp_q;

  wire logic aw_take;
  wire logic w_take;
  wire logic wr_fire;

  // each channel is accepted on its own, in either order
  // take only on a real handshake, else a request still held after reset lands twice
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take  = s_axi_wvalid & s_axi_wready;
  // the write commits once both halves are held and no response is pending
  assign wr_fire = aw_full_q & w_full_q & ~bvalid_q;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      aw_addr_q <= '0;
      aw_full_q <= 1'b0;
    end else if (aw_take) begin
      aw_addr_q <= s_axi_awaddr;
      aw_full_q <= 1'b1;
    end else if (wr_fire) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      w_data_q  <= '0;
      w_lane0_q <= 1'b0;
      w_full_q  <= 1'b0;
    end else if (w_take) begin
      w_data_q  <= s_axi_wdata[RW-1:0];
      w_lane0_q <= s_axi_wstrb[0];
      w_full_q  <= 1'b1;
    end else if (wr_fire) begin
      w_full_q  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // write address decode

  wire logic wr_ctrl;
  wire logic wr_drive_ro;
  wire logic [NR-1:0] wr_role;
  wire logic [NR-1:0] wr_func;
  wire logic wr_hit;
  wire logic wr_en;

  // narrow registers only live in byte lane 0; other lanes are ignored
  assign wr_en       = wr_fire & w_lane0_q;
  assign wr_ctrl     = (aw_addr_q == lcd_bias_pkg::OFS_CONTROL);
  assign wr_drive_ro = (aw_addr_q == lcd_bias_pkg::OFS_DRIVE);

  for (genvar r = 0; r < NR; r++) begin : g_wdec
    assign wr_role[r] = (aw_addr_q == lcd_bias_pkg::OFS_ROLE_0
                         + 8'(r) * lcd_bias_pkg::OFS_STEP);
    assign wr_func[r] = (aw_addr_q == lcd_bias_pkg::OFS_FUNC_0
                         + 8'(r) * lcd_bias_pkg::OFS_STEP);
  end

  assign wr_hit = wr_ctrl | wr_drive_ro | (|wr_role) | (|wr_func);

  // unmapped writes still answer, with an error, so no master hangs
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= lcd_bias_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? lcd_bias_pkg::RESP_OKAY : lcd_bias_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control and pin registers

  logic [RW-1:0]      ctrl_raw;
  logic [RW-1:0]      role_q [NR];
  logic [RW-1:0]      func_q [NR];
  lcd_bias_pkg::ctrl_t ctrl;

  masked_byte_reg #(
    .WR_MASK (lcd_bias_pkg::CTRL_WR_MASK),
    .RESET   (lcd_bias_pkg::CTRL_RESET)
  ) u_ctrl (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_en & wr_ctrl),
    .wr_data (w_data_q),
    .value_q (ctrl_raw)
  );

  assign ctrl.frame            = ctrl_raw[lcd_bias_pkg::CTRL_FRAME_BIT];
  assign ctrl.bias_current_sel = ctrl_raw[lcd_bias_pkg::CTRL_BIAS_HI:
                                          lcd_bias_pkg::CTRL_BIAS_LO];
  assign ctrl.lcd_master_on    = ctrl_raw[lcd_bias_pkg::CTRL_ON_BIT];

  for (genvar r = 0; r < NR; r++) begin : g_regs
    // last role register only holds six pins
    masked_byte_reg #(
      .WR_MASK ((r == NR - 1) ? lcd_bias_pkg::ROLE3_WR_MASK : lcd_bias_pkg::ROLE_WR_MASK),
      .RESET   (lcd_bias_pkg::ROLE_RESET)
    ) u_role (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .wr_en   (wr_en & wr_role[r]),
      .wr_data (w_data_q),
      .value_q (role_q[r])
    );
    masked_byte_reg #(
      .WR_MASK ((r == NR - 1) ? lcd_bias_pkg::ROLE3_WR_MASK : lcd_bias_pkg::ROLE_WR_MASK),
      .RESET   (lcd_bias_pkg::FUNC_RESET)
    ) u_func (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .wr_en   (wr_en & wr_func[r]),
      .wr_data (w_data_q),
      .value_q (func_q[r])
    );
  end

  // flatten: pin k sits at bit k mod 8 of register k / 8
  wire logic [NR*RW-1:0] role_flat;
  wire logic [NR*RW-1:0] func_flat;

  assign role_flat = {role_q[3], role_q[2], role_q[1], role_q[0]};
  assign func_flat = {func_q[3], func_q[2], func_q[1], func_q[0]};

  ////////////////////////////////////////////////////////////////////////////////
  // per-pin level decode

  for (genvar p = 0; p < NP; p++) begin : g_pin
    pin_level_decode u_dec (
      .ref_clk       (ref_clk),
      .sys_rst       (sys_rst),
      .lcd_master_on (ctrl.lcd_master_on),
      .frame         (ctrl.frame),
      .pin_role_bit  (role_flat[p]),
      .func_sel      (func_flat[p]),
      .pin_data      (pin_data[p]),
      .level_q       (pin_level[p]),
      .drive_q       (pin_lcd_drive[p])
    );
  end

  // bias string select goes out registered with the rest of the drive
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bias_current_sel <= lcd_bias_pkg::CTRL_T_RESET.bias_current_sel;
    end else begin
      bias_current_sel <= ctrl.bias_current_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read channel

  logic                                rvalid_q;
  logic [lcd_bias_pkg::AXI_DATA_W-1:0] rdata_q;
  logic [1:0]                          rresp_q;

  wire logic ar_take;
  wire logic rd_ctrl;
  wire logic rd_drive;
  wire logic [NR-1:0] rd_role;
  wire logic [NR-1:0] rd_func;
  wire logic rd_hit;
  wire logic [lcd_bias_pkg::AXI_DATA_W-1:0] rd_mux;
  wire logic [lcd_bias_pkg::AXI_DATA_W-1:0] drive_word;
  logic [RW-1:0] rd_byte;

  // one read in flight; address accepted only while no data is pending
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign rd_ctrl  = (s_axi_araddr == lcd_bias_pkg::OFS_CONTROL);
  assign rd_drive = (s_axi_araddr == lcd_bias_pkg::OFS_DRIVE);

  for (genvar r = 0; r < NR; r++) begin : g_rdec
    assign rd_role[r] = (s_axi_araddr == lcd_bias_pkg::OFS_ROLE_0
                         + 8'(r) * lcd_bias_pkg::OFS_STEP);
    assign rd_func[r] = (s_axi_araddr == lcd_bias_pkg::OFS_FUNC_0
                         + 8'(r) * lcd_bias_pkg::OFS_STEP);
  end

  assign rd_hit = rd_ctrl | rd_drive | (|rd_role) | (|rd_func);

  // live pin ownership, shows the block's own state
  assign drive_word = {{(lcd_bias_pkg::AXI_DATA_W - NP){1'b0}}, pin_lcd_drive};

  always_comb begin
    rd_byte = '0;
    for (int r = 0; r < NR; r++) begin
      if (rd_role[r]) begin
        rd_byte = role_q[r];
      end
      if (rd_func[r]) begin
        rd_byte = func_q[r];
      end
    end
    if (rd_ctrl) begin
      rd_byte = ctrl_raw;
    end
  end

  assign rd_mux = rd_drive ? drive_word
                           : {{(lcd_bias_pkg::AXI_DATA_W - RW){1'b0}}, rd_byte};

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= lcd_bias_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_hit ? lcd_bias_pkg::RESP_OKAY : lcd_bias_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // ready flags straight from flops

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      // a ready is high exactly when the matching holding slot is free next cycle
      s_axi_awready <= ~(aw_full_q | aw_take) | wr_fire;
      s_axi_wready  <= ~(w_full_q | w_take) | wr_fire;
      s_axi_arready <= ~(rvalid_q | ar_take) | (rvalid_q & s_axi_rready);
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule // lcd_bias_driver

`default_nettype wire

/* File: hdl/lcd_bias_pkg.sv */
`default_nettype none

package lcd_bias_pkg;

  // geometry
  localparam int unsigned PIN_COUNT   = 30;
  localparam int unsigned ROLE_REGS   = 4;
  localparam int unsigned REG_WIDTH   = 8;
  localparam int unsigned AXI_DATA_W  = 32;
  localparam int unsigned AXI_ADDR_W  = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_ROLE_0  = 8'h04;
  localparam logic [7:0] OFS_ROLE_1  = 8'h08;
  localparam logic [7:0] OFS_ROLE_2  = 8'h0c;
  localparam logic [7:0] OFS_ROLE_3  = 8'h10;
  localparam logic [7:0] OFS_FUNC_0  = 8'h14;
  localparam logic [7:0] OFS_FUNC_1  = 8'h18;
  localparam logic [7:0] OFS_FUNC_2  = 8'h1c;
  localparam logic [7:0] OFS_FUNC_3  = 8'h20;
  localparam logic [7:0] OFS_DRIVE   = 8'h24;
  localparam logic [7:0] OFS_STEP    = 8'h04;

  ////////////////////////////////////////////////////////////////////////////////
  // lcd_control fields
  localparam int unsigned CTRL_FRAME_BIT  = 7;
  localparam int unsigned CTRL_BIAS_HI    = 6;
  localparam int unsigned CTRL_BIAS_LO    = 5;
  localparam int unsigned CTRL_ON_BIT     = 4;
  localparam logic [7:0]  CTRL_WR_MASK    = 8'hf0;
  localparam logic [7:0]  ROLE_WR_MASK    = 8'hff;
  localparam logic [7:0]  ROLE3_WR_MASK   = 8'h3f;

  // reset values
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [7:0]  ROLE_RESET      = 8'h00;
  localparam logic [7:0]  FUNC_RESET      = 8'h00;

  // axi responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // one-hot drive level per pin
  typedef enum logic [3:0] {
    LVL_VSS        = 4'h1,
    LVL_THIRD      = 4'h2,
    LVL_TWO_THIRDS = 4'h4,
    LVL_VDD        = 4'h8
  } level_t;

  typedef struct packed {
    logic       frame;
    logic [1:0] bias_current_sel;
    logic       lcd_master_on;
  } ctrl_t;

  localparam ctrl_t CTRL_T_RESET = '{frame: 1'b0, bias_current_sel: 2'h0,
                                     lcd_master_on: 1'b0};

endpackage

`default_nettype wire

/* File: hdl/masked_byte_reg.sv */
`timescale 1ns/1ps
`default_nettype none

module masked_byte_reg #(
  parameter logic [7:0] WR_MASK = 8'hff,
  parameter logic [7:0] RESET   = 8'h00
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // write side
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // stored value
  output logic      [7:0] value_q
);

  logic [7:0] value_d;

  // unimplemented bits stay at zero whatever is written
  assign value_d = wr_en ? (wr_data & WR_MASK) : value_q;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      value_q <= RESET;
    end else begin
      value_q <= value_d;
    end
  end

endmodule // masked_byte_reg

`default_nettype wire

/* File: hdl/pin_level_decode.sv */
`timescale 1ns/1ps
`default_nettype none

module pin_level_decode (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  // controls
  input  wire logic                 lcd_master_on,
  input  wire logic                 frame,
  input  wire logic                 pin_role_bit,
  input  wire logic                 func_sel,
  input  wire logic                 pin_data,
  // pin drive
  output lcd_bias_pkg::level_t      level_q,
  output logic                      drive_q
);

  lcd_bias_pkg::level_t level_d;
  wire logic            drive_d;
  wire logic            common_pin;
  wire logic            segment_pin;
  wire logic            far_level;

  assign segment_pin = pin_role_bit;
  assign common_pin  = ~pin_role_bit;
  // data 1 picks the outer level of the pair; data 0 the inner bias level
  assign far_level   = pin_data;

  // lcd drive follows enable and function select, never the port direction
  assign drive_d = lcd_master_on & func_sel;

  always_comb begin
    level_d = lcd_bias_pkg::LVL_VSS;
    if (!lcd_master_on) begin
      level_d = lcd_bias_pkg::LVL_VSS;
    end else if (!frame) begin
      if (common_pin) begin
        level_d = far_level ? lcd_bias_pkg::LVL_VDD : lcd_bias_pkg::LVL_THIRD;
      end else if (segment_pin) begin
        level_d = far_level ? lcd_bias_pkg::LVL_VSS : lcd_bias_pkg::LVL_TWO_THIRDS;
      end
    end else begin
      if (common_pin) begin
        level_d = far_level ? lcd_bias_pkg::LVL_VSS : lcd_bias_pkg::LVL_TWO_THIRDS;
      end else if (segment_pin) begin
        level_d = far_level ? lcd_bias_pkg::LVL_VDD : lcd_bias_pkg::LVL_THIRD;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      level_q <= lcd_bias_pkg::LVL_VSS;
      drive_q <= 1'b0;
    end else begin
      level_q <= level_d;
      drive_q <= drive_d;
    end
  end

endmodule // pin_level_decode

`default_nettype wire

/* File: sim/lcd_bias_driver_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

module lcd_bias_driver_chk (
  // clock and reset
  input wire logic                                ref_clk,
  input wire logic                                sys_rst,
  // bus handshakes
  input wire logic                                s_axi_awvalid,
  input wire logic                                s_axi_awready,
  input wire logic                                s_axi_wvalid,
  input wire logic                                s_axi_wready,
  input wire logic [1:0]                          s_axi_bresp,
  input wire logic                                s_axi_bvalid,
  input wire logic                                s_axi_bready,
  input wire logic                                s_axi_arvalid,
  input wire logic                                s_axi_arready,
  input wire logic [lcd_bias_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  input wire logic                                s_axi_rvalid,
  input wire logic                                s_axi_rready,
  // pins
  input wire logic [lcd_bias_pkg::PIN_COUNT-1:0]  pin_data,
  input wire lcd_bias_pkg::level_t                pin_level [lcd_bias_pkg::PIN_COUNT],
  input wire logic [lcd_bias_pkg::PIN_COUNT-1:0]  pin_lcd_drive,
  input wire logic [1:0]                          bias_current_sel
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////
  property p_rst_quiet;
    disable iff (1'b0) sys_rst |=> pin_level[0] == lcd_bias_pkg::LVL_VSS
      && pin_lcd_drive == '0 && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not quiet in reset");
  property p_onehot;
    $onehot(pin_level[0]) && $onehot(pin_level[29]);
  endproperty
  a_onehot: assert property (p_onehot) else $error("level select not one-hot");
  // no register commit in the window, so only the data bit moved
  property p_data_flip;
    $changed(pin_data[0]) && !s_axi_bvalid && pin_lcd_drive[0]
      |=> pin_level[0] != $past(pin_level[0]);
  endproperty
  a_data_flip: assert property (p_data_flip) else $error("data bit did not move level");
  property p_drive_keep;
    $changed(pin_data) && !s_axi_bvalid |=> $stable(pin_lcd_drive);
  endproperty
  a_drive_keep: assert property (p_drive_keep) else $error("drive followed data");
  property p_bias_keep;
    !s_axi_bvalid |=> $stable(bias_current_sel);
  endproperty
  a_bias_keep: assert property (p_bias_keep) else $error("bias moved without write");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_ar_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_ar_answer: assert property (p_ar_answer) else $error("read not answered");
  property p_w_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_w_answer: assert property (p_w_answer) else $error("write not answered");

  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == lcd_bias_pkg::RESP_SLVERR);
  c_all_on: cover property (pin_lcd_drive == 30'h3fffffff);
  c_bias_max: cover property (bias_current_sel == 2'h3);
endmodule // lcd_bias_driver_chk

bind lcd_bias_driver lcd_bias_driver_chk i_lcd_bias_driver_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pin_data(pin_data),
  .pin_level(pin_level), .pin_lcd_drive(pin_lcd_drive), .bias_current_sel(bias_current_sel)
);

`default_nettype wire

/* File: sim/lcd_panel_model.sv */
`timescale 1ns/1ps
`default_nettype none

module lcd_panel_model (
  // clock
  input wire logic                               ref_clk,
  // electrodes
  input wire lcd_bias_pkg::level_t               pin_level [lcd_bias_pkg::PIN_COUNT],
  input wire logic [lcd_bias_pkg::PIN_COUNT-1:0] pin_lcd_drive,
  // electrode potential in thirds of supply
  output logic [1:0]                             thirds [lcd_bias_pkg::PIN_COUNT]
);
  logic [1:0] tick = 2'h0;

  // a released electrode floats: show a moving pattern, never a stale level
  always @(posedge ref_clk) begin
    tick <= tick + 2'h1;
    for (int i = 0; i < 30; i++)
      thirds[i] <= pin_lcd_drive[i] ? 2'($clog2(pin_level[i])) : tick;
  end
endmodule // lcd_panel_model

`default_nettype wire

/* File: sim/software_lcd_bias_driver_test.sv */
`timescale 1ns/1ps
`default_nettype none

module software_lcd_bias_driver_test;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [29:0] pin_data = 30'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bias_current_sel;
  logic [31:0] s_axi_rdata;
  logic [29:0] pin_lcd_drive;
  logic [1:0]  thirds [30];
  lcd_bias_pkg::level_t pin_level [30];
  int          bad_count = 0;
  int          n_compared = 0;
  logic [29:0] rl, fn;
  logic [7:0]  c;

  always #5 ref_clk = ~ref_clk;

  lcd_bias_driver i_lcd_bias_driver (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pin_data(pin_data), .pin_level(pin_level),
    .pin_lcd_drive(pin_lcd_drive), .bias_current_sel(bias_current_sel)
  );

  lcd_panel_model i_lcd_panel_model (
    .ref_clk(ref_clk), .pin_level(pin_level), .pin_lcd_drive(pin_lcd_drive), .thirds(thirds)
  );

  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    do @(posedge ref_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(er));
    // one edge passes so the next call never re-raises bready in this step
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", 32'(s_axi_rresp), 32'(er));
    @(posedge ref_clk);
  endtask

  // one-hot: 1 ground, 2 one third, 4 two thirds, 8 supply
  function automatic logic [3:0] exp_lvl(input logic on, f, r, d);
    if (!on) return 4'h1;
    case ({f, r, d})
      3'b000: return 4'h2;
      3'b001: return 4'h8;
      3'b010: return 4'h4;
      3'b011: return 4'h1;
      3'b100: return 4'h4;
      3'b101: return 4'h1;
      3'b110: return 4'h2;
      default: return 4'h8;
    endcase
  endfunction

  task automatic chk_pins();
    logic [3:0] e;
    repeat (3) @(posedge ref_clk);
    chk("bias", 32'(bias_current_sel), 32'(c[6:5]));
    chk("drive", 32'(pin_lcd_drive), 32'(fn & {30{c[4]}}));
    for (int i = 0; i < 30; i++) begin
      e = exp_lvl(c[4], c[7], rl[i], pin_data[i]);
      chk("level", 32'(pin_level[i]), 32'(e));
      if (c[4] && fn[i]) chk("panel", 32'(thirds[i]), 32'($clog2(e)));
    end
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    give_verdict();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    for (int a = 0; a <= 'h24; a += 4) rd(8'(a), 32'h0, 2'h0);
    $display("test reset values done");
    wr(8'h00, 32'hff, 2'h0);
    rd(8'h00, 32'hf0, 2'h0);
    wr(8'h10, 32'hff, 2'h0);
    rd(8'h10, 32'h3f, 2'h0);
    wr(8'h28, 32'hff, 2'h2);
    rd(8'h28, 32'h0, 2'h2);
    $display("test register access done");
    // distinct role patterns per register expose a wrong bit or byte mapping
    wr(8'h04, 32'h55, 2'h0);
    wr(8'h08, 32'haa, 2'h0);
    wr(8'h0c, 32'h0f, 2'h0);
    wr(8'h10, 32'h3c, 2'h0);
    for (int a = 'h14; a <= 'h20; a += 4) wr(8'(a), 32'hff, 2'h0);
    rl = {6'h3c, 8'h0f, 8'haa, 8'h55};
    fn = '1;
    for (int k = 0; k < 8; k++) begin
      c = {k[0], k[2:1], 1'b1, 4'h0};
      wr(8'h00, {24'h0, c}, 2'h0);
      pin_data <= {15{k[1] ? 2'b01 : 2'b10}};
      chk_pins();
      pin_data <= ~pin_data;
      chk_pins();
    end
    c = 8'he0;
    wr(8'h00, 32'he0, 2'h0);
    chk_pins();
    $display("test level decode done");
    wr(8'h14, 32'h0f, 2'h0);
    wr(8'h20, 32'h00, 2'h0);
    c = 8'h10;
    wr(8'h00, 32'h10, 2'h0);
    fn = {6'h0, 8'hff, 8'hff, 8'h0f};
    chk_pins();
    rd(8'h24, {2'h0, fn}, 2'h0);
    $display("test function select done");
    // second reset in mid-run clears every register and the drive
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    rd(8'h24, 32'h0, 2'h0);
    c = 8'h00;
    fn = '0;
    chk_pins();
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule // software_lcd_bias_driver_test

`default_nettype wire
